// ==== design/ihbp_device.sv ====
`timescale 1ns/100ps
`default_nettype none
module ihbp_device
   import ihbp_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rstn,
   input  wire logic       clk_en,
   ihbp_if.device          bus,
   input  wire logic [7:0] rd_data,
   output logic            rd_taken,
   output logic            wr_valid,
   output logic            wr_is_cmd,
   output logic [7:0]      wr_data,
   output logic            cfg_enable_style
);
   typedef struct packed {
      logic [SYNC_STAGES-1:0] cs_s;
      logic [SYNC_STAGES-1:0] rd_s;
      logic [SYNC_STAGES-1:0] wr_s;
      logic [SYNC_STAGES-1:0] cd_s;
      logic [SYNC_STAGES-1:0] st_s;
      logic [7:0]             db_s1;
      logic [7:0]             db_s2;
      logic                   act_q;
      ihbp_xfer_t             kind_q;
      logic                   drive_q;
      logic [7:0]             dout_q;
      logic                   wv_q;
      logic                   wc_q;
      logic [7:0]             wd_q;
      logic                   rt_q;
   } ihbp_dev_t;

   ihbp_dev_t s_q, s_d;

   // elaboration checks
   if (SYNC_STAGES < 2) begin : g_sync_check
      $error("SYNC_STAGES must be at least 2");
   end
   if (STYLE_GENERIC == STYLE_ENABLE || CD_COMMAND == CD_DATA) begin : g_code_check
      $error("bus style or command codes not distinct");
   end

   // shift a pin into its synchroniser chain
   function automatic logic [SYNC_STAGES-1:0] sync_shift(input logic [SYNC_STAGES-1:0] chain,
                                                         input logic                   pin);
      sync_shift = {chain[SYNC_STAGES-2:0], pin};
   endfunction

   // last flop of a synchroniser chain
   function automatic logic synced(input logic [SYNC_STAGES-1:0] chain);
      synced = chain[SYNC_STAGES-1];
   endfunction

   // strobe asserted, per bus style
   function automatic logic strobe_active(input logic st,
                                          input logic rd,
                                          input logic wr);
      if (st == STYLE_ENABLE) begin
         strobe_active = rd;
      end else begin
         strobe_active = !rd || !wr;
      end
   endfunction

   // host reads from the device, per bus style
   function automatic logic read_request(input logic st,
                                         input logic rd,
                                         input logic wr);
      if (st == STYLE_ENABLE) begin
         read_request = wr;
      end else begin
         read_request = !rd;
      end
   endfunction

   // transfer kind from direction and command/data line
   function automatic ihbp_xfer_t classify(input logic st,
                                           input logic rd,
                                           input logic wr,
                                           input logic cd);
      if (read_request(st, rd, wr)) begin
         classify = IHBP_XFER_READ;
      end else if (cd == CD_COMMAND) begin
         classify = IHBP_XFER_CMD;
      end else begin
         classify = IHBP_XFER_WDATA;
      end
   endfunction

   // write kinds: command or parameter data
   function automatic logic is_write(input ihbp_xfer_t kind);
      is_write = (kind == IHBP_XFER_CMD) || (kind == IHBP_XFER_WDATA);
   endfunction

   // synchronised pin levels and strobe edges
   logic       cs_ok;
   logic       st;
   logic       rdl;
   logic       wrl;
   logic       cdl;
   logic       act;
   logic       act_rise;
   logic       act_fall;
   ihbp_xfer_t kind_now;

   always_comb begin
      s_d = s_q;

      // synchronised view of the pins
      cs_ok = !synced(s_q.cs_s);
      st    = synced(s_q.st_s);
      rdl   = synced(s_q.rd_s);
      wrl   = synced(s_q.wr_s);
      cdl   = synced(s_q.cd_s);

      // strobe edges, one action per transfer
      act      = cs_ok && strobe_active(st, rdl, wrl);
      act_rise = act && !s_q.act_q;
      act_fall = !act && s_q.act_q;
      kind_now = classify(st, rdl, wrl, cdl);

      // two-flop synchronisers on every input pin except host_address_bus
      s_d.cs_s  = sync_shift(s_q.cs_s, bus.cs_n);
      s_d.rd_s  = sync_shift(s_q.rd_s, bus.rd_en);
      s_d.wr_s  = sync_shift(s_q.wr_s, bus.wr_rw);
      s_d.cd_s  = sync_shift(s_q.cd_s, bus.command_data_select);
      s_d.st_s  = sync_shift(s_q.st_s, bus.bus_style_select);
      s_d.db_s1 = bus.host_data_bus;
      s_d.db_s2 = s_q.db_s1;
      s_d.act_q = act;

      // single-cycle pulses
      s_d.wv_q = 1'b0;
      s_d.rt_q = 1'b0;

      // strobe start: note the kind, load read data
      if (act_rise) begin
         s_d.kind_q = kind_now;
         if (kind_now == IHBP_XFER_READ) begin
            s_d.drive_q = 1'b1;
            s_d.dout_q  = rd_data;
            s_d.rt_q    = 1'b1;
         end
      end

      // strobe end: release the bus, hand over a write
      if (act_fall) begin
         s_d.drive_q = 1'b0;
         if (is_write(s_q.kind_q)) begin
            s_d.wv_q = 1'b1;
            s_d.wc_q = (s_q.kind_q == IHBP_XFER_CMD);
            s_d.wd_q = s_q.db_s2;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_q.cs_s    <= '1;
         s_q.rd_s    <= '1;
         s_q.wr_s    <= '1;
         s_q.cd_s    <= '0;
         s_q.st_s    <= '0;
         s_q.db_s1   <= DATA_RESET;
         s_q.db_s2   <= DATA_RESET;
         s_q.act_q   <= 1'b0;
         s_q.kind_q  <= IHBP_XFER_NONE;
         s_q.drive_q <= 1'b0;
         s_q.dout_q  <= DATA_RESET;
         s_q.wv_q    <= 1'b0;
         s_q.wc_q    <= 1'b0;
         s_q.wd_q    <= DATA_RESET;
         s_q.rt_q    <= 1'b0;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   // bus pins
   assign bus.db_dev_o    = s_q.dout_q;
   assign bus.db_dev_oe_n = !s_q.drive_q;

   // handover to the core
   assign rd_taken        = s_q.rt_q;
   assign wr_valid        = s_q.wv_q;
   assign wr_is_cmd       = s_q.wc_q;
   assign wr_data         = s_q.wd_q;
   assign cfg_enable_style = synced(s_q.st_s);
endmodule // ihbp_device
`default_nettype wire

// ==== design/ihbp_pkg.sv ====
package ihbp_pkg;
   localparam int unsigned CLK_MHZ          = 200;
   localparam int unsigned SYS_PERIODS_WSETUP = 2;
   localparam int unsigned SYS_PERIODS_RVALID = 4;
   localparam int unsigned SYS_PERIODS_ACTIVE = 5;
   localparam int unsigned SYS_PERIODS_CYC_RD = 6;
   localparam int unsigned SYS_PERIODS_CYC_WW = 7;
   localparam int unsigned SYS_PERIODS_CYC_WR = 10;
   localparam int unsigned SYS_PERIODS_INA_RD = 1;
   localparam int unsigned SYS_PERIODS_INA_WW = 2;
   localparam int unsigned SYS_PERIODS_INA_WR = 5;
   localparam int unsigned MARGIN_CYCLES    = 1;
   localparam int unsigned SYNC_STAGES      = 2;
   localparam logic [7:0]  DATA_RESET       = 8'h00;
   localparam logic        STYLE_GENERIC    = 1'b0;
   localparam logic        STYLE_ENABLE     = 1'b1;
   localparam logic        CD_COMMAND       = 1'b1;
   localparam logic        CD_DATA          = 1'b0;
   typedef enum logic [1:0] {
      IHBP_XFER_NONE,
      IHBP_XFER_CMD,
      IHBP_XFER_WDATA,
      IHBP_XFER_READ
   } ihbp_xfer_t;
endpackage

// ==== design/ihbp_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface ihbp_if;
   logic       cs_n;
   logic       rd_en;
   logic       wr_rw;
   logic       command_data_select;
   logic       bus_style_select;
   logic [15:0] host_address_bus;
   logic [7:0] db_host_o;
   logic       db_host_oe_n;
   logic [7:0] db_dev_o;
   logic       db_dev_oe_n;
   logic [7:0] host_data_bus;
   assign host_data_bus = !db_dev_oe_n ? db_dev_o : (!db_host_oe_n ? db_host_o : 8'hFF);
   modport device (
      input  cs_n, rd_en, wr_rw, command_data_select, bus_style_select, host_address_bus, host_data_bus,
      output db_dev_o, db_dev_oe_n
   );
   modport host (
      output cs_n, rd_en, wr_rw, command_data_select, bus_style_select, host_address_bus, db_host_o,
      output db_host_oe_n,
      input  host_data_bus
   );
endinterface
`default_nettype wire

// ==== design/ihbp_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module ihbp_host
   import ihbp_pkg::*;
#(
   parameter int unsigned SYS_DIV = 1
)(
   input  wire logic       core_clk,
   input  wire logic       rstn,
   input  wire logic       clk_en,
   ihbp_if.host            bus,
   input  wire logic       style,
   input  wire logic       req_valid,
   input  wire logic       req_read,
   input  wire logic       req_cmd,
   input  wire logic [7:0] req_data,
   output logic            req_ready,
   output logic            rsp_valid,
   output logic [7:0]      rsp_data
);
   if (SYS_DIV < 1 || SYS_DIV > 64) begin : g_div_check
      $error("SYS_DIV out of range");
   end
   localparam int unsigned SYNC_PAD = 4;
   localparam logic [9:0] T_ACT = 10'((SYS_PERIODS_ACTIVE + SYNC_PAD) * SYS_DIV);
   localparam logic [9:0] T_SU  = 10'((SYS_PERIODS_WSETUP + MARGIN_CYCLES + SYNC_PAD) * SYS_DIV);
   localparam logic [9:0] T_I_RD = 10'((SYS_PERIODS_CYC_RD + SYNC_PAD) * SYS_DIV);
   localparam logic [9:0] T_I_WW = 10'((SYS_PERIODS_CYC_WW + MARGIN_CYCLES + SYNC_PAD) * SYS_DIV);
   localparam logic [9:0] T_I_WR = 10'((SYS_PERIODS_CYC_WR + MARGIN_CYCLES + SYNC_PAD) * SYS_DIV);
   typedef enum logic [1:0] {IHBP_H_IDLE, IHBP_H_SETUP, IHBP_H_ACT, IHBP_H_GAP} ihbp_hst_t;
   typedef struct packed {
      ihbp_hst_t  st;
      logic [9:0] cnt;
      logic       rd;
      logic       cmd;
      logic       last_wr;
      logic [7:0] d;
      logic       rv;
      logic [7:0] rdat;
   } ihbp_host_t;
   ihbp_host_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.rv = 1'b0;
      case (s_q.st)
         IHBP_H_IDLE: begin
            if (req_valid) begin
               s_d.rd = req_read;
               s_d.cmd = req_cmd;
               s_d.d = req_data;
               s_d.cnt = (s_q.last_wr && req_read) ? T_SU + (T_I_WR - T_I_WW) : T_SU;
               s_d.st = IHBP_H_SETUP;
            end
         end
         IHBP_H_SETUP: begin
            if (s_q.cnt == 10'h000) begin
               s_d.cnt = T_ACT;
               s_d.st = IHBP_H_ACT;
            end else begin
               s_d.cnt = s_q.cnt - 10'h001;
            end
         end
         IHBP_H_ACT: begin
            if (s_q.cnt == 10'h000) begin
               if (s_q.rd) begin
                  s_d.rv = 1'b1;
                  s_d.rdat = bus.host_data_bus;
               end
               s_d.cnt = s_q.rd ? T_I_RD : T_I_WW;
               s_d.last_wr = !s_q.rd;
               s_d.st = IHBP_H_GAP;
            end else begin
               s_d.cnt = s_q.cnt - 10'h001;
            end
         end
         IHBP_H_GAP: begin
            if (s_q.cnt == 10'h000) begin
               s_d.st = IHBP_H_IDLE;
            end else begin
               s_d.cnt = s_q.cnt - 10'h001;
            end
         end
         default: s_d.st = IHBP_H_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.st <= IHBP_H_IDLE;
      end else if (clk_en) begin
         s_q <= s_d;
      end
   end

   logic active, busy;
   assign active = (s_q.st == IHBP_H_ACT);
   assign busy   = (s_q.st != IHBP_H_IDLE);
   // write-then-read needs the longer gap: its excess over the write-write gap is added to the read's setup count
   assign req_ready = !busy && clk_en;
   assign bus.cs_n = !busy;
   assign bus.bus_style_select = style;
   assign bus.host_address_bus = {15'h0000, s_q.cmd ? CD_COMMAND : CD_DATA};
   assign bus.command_data_select = s_q.cmd ? CD_COMMAND : CD_DATA;
   // generic: active low strobes; enable mode: rd_en high, wr_rw direction
   assign bus.rd_en = (style == STYLE_ENABLE) ? active : !(active && s_q.rd);
   assign bus.wr_rw = (style == STYLE_ENABLE) ? s_q.rd : !(active && !s_q.rd);
   assign bus.db_host_o = s_q.d;
   assign bus.db_host_oe_n = !(busy && !s_q.rd);
   assign rsp_valid = s_q.rv;
   assign rsp_data  = s_q.rdat;
endmodule // ihbp_host
`default_nettype wire

// ==== verification/ihbp_props.sv ====
`timescale 1ns/100ps
`default_nettype none
module ihbp_props (
   input wire logic        core_clk,
   input wire logic        rstn,
   input wire logic        cs_n,
   input wire logic        rd_en,
   input wire logic        wr_rw,
   input wire logic        bus_style_select,
   input wire logic        command_data_select,
   input wire logic [15:0] host_address_bus,
   input wire logic        db_host_oe_n,
   input wire logic        db_dev_oe_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   wire logic rd_act  = !cs_n && (bus_style_select ? (rd_en && wr_rw) : !rd_en);
   wire logic any_act = !cs_n && (bus_style_select ? rd_en : (!rd_en || !wr_rw));
   property p_rd_drive; $rose(rd_act) |-> ##[1:5] !db_dev_oe_n; endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("read data late");
   property p_drive_cause; $fell(db_dev_oe_n) |-> rd_act; endproperty
   a_drive_cause: assert property (p_drive_cause) else $error("drive without read");
   property p_release; $fell(rd_act) |-> ##[1:5] db_dev_oe_n; endproperty
   a_release: assert property (p_release) else $error("bus not released");
   property p_no_fight; db_dev_oe_n || db_host_oe_n; endproperty
   a_no_fight: assert property (p_no_fight) else $error("both ends drive");
   property p_cs_gate; cs_n [*6] |-> db_dev_oe_n; endproperty
   a_cs_gate: assert property (p_cs_gate) else $error("drive while deselected");
   property p_width; $rose(any_act) |-> any_act [*5]; endproperty
   a_width: assert property (p_width) else $error("strobe too short");
   property p_setup; ($rose(wr_rw) && !bus_style_select && !cs_n) |-> !$past(db_host_oe_n, 3); endproperty
   a_setup: assert property (p_setup) else $error("write data setup short");
   property p_gap; ($rose(wr_rw) && !bus_style_select && !cs_n) |-> (wr_rw && rd_en) [*3]; endproperty
   a_gap: assert property (p_gap) else $error("inactive gap short");
   property p_addr; !cs_n |-> host_address_bus == {15'h0000, command_data_select}; endproperty
   a_addr: assert property (p_addr) else $error("address lines wrong");
   property p_reset; $rose(rstn) |-> db_dev_oe_n && db_host_oe_n && cs_n; endproperty
   a_reset: assert property (p_reset) else $error("outputs active after reset");
endmodule // ihbp_props
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic       core_clk, rstn, clk_en, style, req_valid, req_read, req_cmd, req_ready;
   logic       rsp_valid, wr_valid, wr_is_cmd, cfg_enable_style, rd_taken;
   logic [7:0] req_data, rsp_data, rd_data, wr_data;
   logic [9:0] exp_q[$];
   int         fail_count, checked, rd_sent, rd_seen;
   ihbp_if bus_if ();
   ihbp_device ihbp_device_i (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .bus(bus_if),
      .rd_data(rd_data), .rd_taken(rd_taken), .wr_valid(wr_valid), .wr_is_cmd(wr_is_cmd), .wr_data(wr_data),
      .cfg_enable_style(cfg_enable_style));
   ihbp_host #(.SYS_DIV(1)) ihbp_host_i (.core_clk(core_clk), .rstn(rstn), .clk_en(clk_en),
      .bus(bus_if), .style(style), .req_valid(req_valid), .req_read(req_read), .req_cmd(req_cmd),
      .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   ihbp_props ihbp_props_i (.core_clk(core_clk), .rstn(rstn), .cs_n(bus_if.cs_n), .rd_en(bus_if.rd_en),
      .wr_rw(bus_if.wr_rw), .bus_style_select(bus_if.bus_style_select),
      .command_data_select(bus_if.command_data_select), .host_address_bus(bus_if.host_address_bus),
      .db_host_oe_n(bus_if.db_host_oe_n), .db_dev_oe_n(bus_if.db_dev_oe_n));
   always #2.5 core_clk = ~core_clk;
   task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] s);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic end_of_test();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one host request, expectation noted
   task automatic xfer(input logic rd, input logic cmd);
      logic [7:0] d;
      d = 8'($urandom);
      while (req_ready !== 1'b1) @(negedge core_clk);
      rd_data = 8'($urandom);
      req_valid = 1'b1;
      req_read = rd;
      req_cmd = cmd;
      req_data = d;
      exp_q.push_back(rd ? {2'b10, rd_data} : {1'b0, cmd, d});
      if (rd) rd_sent++;
      @(negedge core_clk);
      req_valid = 1'b0;
   endtask
   // results in order of request
   always @(negedge core_clk) begin
      if (rd_taken === 1'b1) rd_seen++;
      if (wr_valid === 1'b1 || rsp_valid === 1'b1) begin
         chk("result", exp_q.pop_front(), rsp_valid ? {2'b10, rsp_data} : {1'b0, wr_is_cmd, wr_data});
      end
   end
   initial begin
      #20000;
      fail_count++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'h671D));
      core_clk = 1'b0;
      rstn = 1'b0;
      clk_en = 1'b1;
      style = 1'b0;
      req_valid = 1'b0;
      req_read = 1'b0;
      req_cmd = 1'b0;
      req_data = 8'h00;
      rd_data = 8'h00;
      repeat (3) @(negedge core_clk);
      rstn = 1'b1;
      for (int m = 0; m < 2; m++) begin
         while (req_ready !== 1'b1) @(negedge core_clk);
         clk_en = 1'b0;
         style = m[0];
         repeat (6) @(negedge core_clk);
         chk("frozen", 10'h000, {9'h000, cfg_enable_style});
         clk_en = 1'b1;
         repeat (6) @(negedge core_clk);
         chk("style", {9'h000, m[0]}, {9'h000, cfg_enable_style});
         for (int k = 0; k < 8; k++) xfer(k[0] ^ k[2], k[1]);
      end
      repeat (60) @(negedge core_clk);
      chk("pending", 10'h000, 10'(exp_q.size()));
      chk("reads", 10'(rd_sent), 10'(rd_seen));
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
